//--- csb_defs.vh
// shared constants for the configuration bypass bridge
`ifndef CSB_DEFS_VH
`define CSB_DEFS_VH

// request header type codes (header dword 0, bits 28:24)
`define CSB_TYPE_MEM 5'h00
`define CSB_TYPE_CFG0 5'h04
`define CSB_TYPE_CFG1 5'h05
`define CSB_TYPE_CPL 5'h0a
`define CSB_MSG_CLASS 2'h2

// header field positions
`define CSB_FMT_MSB 31
`define CSB_FMT_LSB 29
`define CSB_TYPE_MSB 28
`define CSB_TYPE_LSB 24
`define CSB_FMT_DATA 1
`define CSB_FMT_4DW 0
`define CSB_LEN_MSB 9
`define CSB_LEN_ONE 10'h001

// completion formats and status codes
`define CSB_FMT_CPL 3'h0
`define CSB_FMT_CPLD 3'h2
`define CSB_ST_SC 3'h0
`define CSB_ST_UR 3'h1
`define CSB_ST_CA 3'h4
`define CSB_BYTE_COUNT 12'h004

// configuration dword indices inside one function
`define CSB_CFG_ID 10'h000
`define CSB_CFG_CMD 10'h001
`define CSB_CFG_CLASS 10'h002
`define CSB_CFG_BAR_LO 10'h004
`define CSB_CFG_BAR_HI 10'h005

// base region zero: 1 MB, 64-bit, prefetchable
`define CSB_BAR_BITS 20
`define CSB_BAR_ATTR 4'hc
`define CSB_CMD_BITS 3

// identification defaults, values arbitrary
`define CSB_VENDOR_ID 16'h5a5a
`define CSB_DEVICE_ID 16'ha5a5
`define CSB_CLASS_REV 32'h00000001

`endif

//--- csb_cpl.v
// completion header formatter for the bypass bridge
`timescale 1ns/1ns
`default_nettype none
`include "csb_defs.vh"

module csb_cpl (
	// completion fields
	input wire [2:0] status_in,
	input wire with_data_in,
	input wire [31:0] data_in,
	input wire [15:0] cpl_id_in,
	input wire [15:0] req_id_in,
	input wire [7:0] tag_in,
	input wire [6:0] lower_addr_in,
	// formatted beat, dword 0 in the low bits
	output wire [255:0] payload_out
);
	wire [31:0] dw0;
	wire [31:0] dw1;
	wire [31:0] dw2;
	wire [31:0] dw3;

	// three-dword header, data in dword 3 only when carried
	assign dw0 = {with_data_in ? `CSB_FMT_CPLD : `CSB_FMT_CPL,
		`CSB_TYPE_CPL, 14'h0000, 9'h000, with_data_in};
	assign dw1 = {cpl_id_in, status_in, 1'b0, `CSB_BYTE_COUNT};
	assign dw2 = {req_id_in, tag_in, 1'b0, lower_addr_in};
	assign dw3 = with_data_in ? data_in : 32'h00000000;
	assign payload_out = {128'h0, dw3, dw2, dw1, dw0};
endmodule
`default_nettype wire

//--- csb_func.v
// configuration space and two data registers of one function
`timescale 1ns/1ns
`default_nettype none
`include "csb_defs.vh"

module csb_func #(
	parameter [15:0] VENDOR_ID = `CSB_VENDOR_ID,
	parameter [15:0] DEVICE_ID = `CSB_DEVICE_ID,
	parameter [31:0] CLASS_REV = `CSB_CLASS_REV
) (
	// clock and reset
	input wire clk_in,
	input wire reset_n_in,
	// configuration access
	input wire cfg_rd_in,
	input wire cfg_wr_in,
	input wire cfg_wresp_req_in,
	input wire [9:0] cfg_dw_in,
	input wire [31:0] cfg_wdata_in,
	input wire [3:0] cfg_be_in,
	output reg cfg_rdata_valid_out,
	output reg [31:0] cfg_rdata_out,
	output reg cfg_wresp_valid_out,
	// register access
	input wire mem_rd_in,
	input wire mem_wr_in,
	input wire mem_sel_in,
	input wire [31:0] mem_wdata_in,
	input wire [3:0] mem_be_in,
	output wire mem_wait_out,
	output wire [31:0] mem_rdata_out,
	// programmed base of region zero
	output wire [63:20] bar_base_out
);
	reg [`CSB_CMD_BITS-1:0] cmd;
	reg [31:20] bar_lo;
	reg [31:0] bar_hi;
	reg [31:0] data_reg [0:1];
	reg mem_done;
	reg [31:0] cfg_word;
	wire cfg_wr_go;
	wire mem_go;
	wire [31:0] bar_lo_merged;

	// byte-lane merge of a write into an old value
	function [31:0] merge;
		input [31:0] old_v;
		input [31:0] new_v;
		input [3:0] be;
		integer i;
		begin
			merge = old_v;
			for (i = 0; i < 4; i = i + 1) begin
				if (be[i])
					merge[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
	endfunction

	// one wait cycle per access so the bridge must honour the stall
	assign mem_wait_out = (mem_rd_in | mem_wr_in) & ~mem_done;
	assign mem_go = (mem_rd_in | mem_wr_in) & mem_done;
	assign mem_rdata_out = data_reg[mem_sel_in];
	assign cfg_wr_go = cfg_wr_in & cfg_wresp_req_in & ~cfg_wresp_valid_out;
	assign bar_base_out = {bar_hi, bar_lo};
	// only the writable window bits survive; the size bits stay zero
	assign bar_lo_merged = merge({bar_lo, 20'h00000}, cfg_wdata_in,
		cfg_be_in);

	// configuration read view; unlisted dwords read as zero
	always @* begin
		case (cfg_dw_in)
		`CSB_CFG_ID: cfg_word = {DEVICE_ID, VENDOR_ID};
		`CSB_CFG_CMD: cfg_word = {29'h0, cmd};
		`CSB_CFG_CLASS: cfg_word = CLASS_REV;
		`CSB_CFG_BAR_LO: cfg_word = {bar_lo, 16'h0000, `CSB_BAR_ATTR};
		`CSB_CFG_BAR_HI: cfg_word = bar_hi;
		default: cfg_word = 32'h00000000;
		endcase
	end

	// answers pulse one cycle, then rest one cycle, and pulse again while the strobe stays high
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cfg_rdata_valid_out <= 1'b0;
			cfg_rdata_out <= 32'h00000000;
			cfg_wresp_valid_out <= 1'b0;
			mem_done <= 1'b0;
			cmd <= {`CSB_CMD_BITS{1'b0}};
			bar_lo <= 12'h000;
			bar_hi <= 32'h00000000;
			data_reg[0] <= 32'h00000000;
			data_reg[1] <= 32'h00000000;
		end else begin
			cfg_rdata_valid_out <= cfg_rd_in & ~cfg_rdata_valid_out;
			cfg_rdata_out <= cfg_word;
			cfg_wresp_valid_out <= cfg_wr_go;
			mem_done <= (mem_rd_in | mem_wr_in) & ~mem_done;
			if (cfg_wr_go && cfg_dw_in == `CSB_CFG_CMD && cfg_be_in[0])
				cmd <= cfg_wdata_in[`CSB_CMD_BITS-1:0];
			if (cfg_wr_go && cfg_dw_in == `CSB_CFG_BAR_LO)
				bar_lo <= bar_lo_merged[31:`CSB_BAR_BITS];
			if (cfg_wr_go && cfg_dw_in == `CSB_CFG_BAR_HI)
				bar_hi <= merge(bar_hi, cfg_wdata_in, cfg_be_in);
			if (mem_go && mem_wr_in)
				data_reg[mem_sel_in] <= merge(data_reg[mem_sel_in],
					mem_wdata_in, mem_be_in);
		end
	end
endmodule
`default_nettype wire

//--- csb_bridge.v
// request-to-register bridge with its own configuration space
//
// Summary of operation
// - take configuration, memory and message requests from the receive stream
// - each function's configuration space lives here, not in the core
// - type 0 configuration reads and writes reach function 0 or 1
// - invalid type 0 configuration requests complete as unsupported
// - valid configuration requests to function 0 or 1 complete successfully
// - single-dword memory requests access a 32-bit register of the function
// - one programmable megabyte window per function; function 0 wins where the two overlap
// - two data registers are provided in each function
// - multi-dword memory writes and messages with data are dropped silently
// - multi-dword memory reads get completer abort; reads missing both windows are unsupported
// - region zero of each function: 1 MB, 64-bit, prefetchable, 20 bits
// - base address decoding is done here, core registers are ignored
// - configuration reads show fixed 16-bit device and vendor codes
// - ready is shown before a request is taken on start with valid
// - configuration read strobes until read data valid, then completes
// - configuration write strobes with response request until response valid
`timescale 1ns/1ns
`default_nettype none
`include "csb_defs.vh"

module csb_bridge #(
	parameter [15:0] VENDOR_ID = `CSB_VENDOR_ID,
	parameter [15:0] DEVICE_ID = `CSB_DEVICE_ID
) (
	// clock and reset
	input wire clk_in,
	input wire reset_n_in,
	// receive stream from the core
	input wire [255:0] rx_stream_payload_in,
	input wire rx_stream_packet_start_in,
	input wire rx_stream_packet_end_in,
	input wire rx_stream_word_valid_in,
	output reg rx_stream_accept_ready_out,
	// transmit stream to the core
	input wire tx_stream_accept_ready_in,
	output reg [255:0] tx_stream_payload_out,
	output reg tx_stream_packet_start_out,
	output reg tx_stream_packet_end_out,
	output reg tx_stream_word_valid_out
);
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_DEC = 3'h1;
	localparam [2:0] ST_CFG_RD = 3'h2;
	localparam [2:0] ST_CFG_WR = 3'h3;
	localparam [2:0] ST_MEM = 3'h4;
	localparam [2:0] ST_DRAIN = 3'h5;
	localparam [2:0] ST_TX = 3'h6;

	reg [2:0] state;
	reg [2:0] next_state;
	reg [2:0] h_fmt;
	reg [4:0] h_type;
	reg [9:0] h_len;
	reg [15:0] h_req;
	reg [7:0] h_tag;
	reg [3:0] h_fbe;
	reg [2:0] h_func;
	reg [9:0] h_reg;
	reg [63:0] h_addr;
	reg [31:0] h_data;
	reg fsel;
	reg next_fsel;
	reg [2:0] next_status;
	reg next_with_data;
	reg [31:0] next_cdata;

	wire [31:0] dw0;
	wire [31:0] dw1;
	wire [31:0] dw2;
	wire [31:0] dw3;
	wire [31:0] dw4;
	wire take;
	wire is_4dw;
	wire has_data;
	wire is_cfg0;
	wire is_cfg1;
	wire is_mem;
	wire is_msg;
	wire one_dw;
	wire hit0;
	wire hit1;
	wire [63:20] bar0;
	wire [63:20] bar1;
	wire [1:0] c_rdv;
	wire [1:0] c_wrv;
	wire [31:0] c_rdata0;
	wire [31:0] c_rdata1;
	wire [1:0] m_wait;
	wire [31:0] m_rdata0;
	wire [31:0] m_rdata1;
	wire sel_rdv;
	wire sel_wrv;
	wire sel_wait;
	wire [31:0] sel_cfg_rdata;
	wire [31:0] sel_mem_rdata;
	wire [255:0] cpl_beat;
	wire [15:0] cpl_id;
	wire [6:0] cpl_lower;

	// split the incoming beat into header dwords
	assign dw0 = rx_stream_payload_in[31:0];
	assign dw1 = rx_stream_payload_in[63:32];
	assign dw2 = rx_stream_payload_in[95:64];
	assign dw3 = rx_stream_payload_in[127:96];
	assign dw4 = rx_stream_payload_in[159:128];

	// a request is taken only on a start beat while ready is shown
	assign take = rx_stream_accept_ready_out & rx_stream_word_valid_in &
		rx_stream_packet_start_in;

	// decode of the captured header
	assign is_4dw = h_fmt[`CSB_FMT_4DW];
	assign has_data = h_fmt[`CSB_FMT_DATA];
	assign is_cfg0 = (h_type == `CSB_TYPE_CFG0);
	assign is_cfg1 = (h_type == `CSB_TYPE_CFG1);
	assign is_mem = (h_type == `CSB_TYPE_MEM);
	assign is_msg = (h_type[4:3] == `CSB_MSG_CLASS);
	assign one_dw = (h_len == `CSB_LEN_ONE);

	// each function's 1 MB window is compared on bits 63:20 only
	assign hit0 = (h_addr[63:20] == bar0);
	assign hit1 = (h_addr[63:20] == bar1);

	// answers of the selected function
	assign sel_rdv = fsel ? c_rdv[1] : c_rdv[0];
	assign sel_wrv = fsel ? c_wrv[1] : c_wrv[0];
	assign sel_wait = fsel ? m_wait[1] : m_wait[0];
	assign sel_cfg_rdata = fsel ? c_rdata1 : c_rdata0;
	assign sel_mem_rdata = fsel ? m_rdata1 : m_rdata0;
	assign cpl_id = {13'h0000, 2'b00, fsel};
	assign cpl_lower = is_cfg0 ? 7'h00 : h_addr[6:0];

	// function 0: configuration space and two registers
	csb_func #(
		.VENDOR_ID(VENDOR_ID),
		.DEVICE_ID(DEVICE_ID),
		.CLASS_REV(`CSB_CLASS_REV)
	) u_func0 (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.cfg_rd_in(state == ST_CFG_RD && !fsel),
		.cfg_wr_in(state == ST_CFG_WR && !fsel),
		.cfg_wresp_req_in(state == ST_CFG_WR && !fsel),
		.cfg_dw_in(h_reg),
		.cfg_wdata_in(h_data),
		.cfg_be_in(h_fbe),
		.cfg_rdata_valid_out(c_rdv[0]),
		.cfg_rdata_out(c_rdata0),
		.cfg_wresp_valid_out(c_wrv[0]),
		.mem_rd_in(state == ST_MEM && !fsel && !has_data),
		.mem_wr_in(state == ST_MEM && !fsel && has_data),
		.mem_sel_in(h_addr[2]),
		.mem_wdata_in(h_data),
		.mem_be_in(h_fbe),
		.mem_wait_out(m_wait[0]),
		.mem_rdata_out(m_rdata0),
		.bar_base_out(bar0)
	);

	// function 1: same layout, own window
	csb_func #(
		.VENDOR_ID(VENDOR_ID),
		.DEVICE_ID(DEVICE_ID),
		.CLASS_REV(`CSB_CLASS_REV)
	) u_func1 (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.cfg_rd_in(state == ST_CFG_RD && fsel),
		.cfg_wr_in(state == ST_CFG_WR && fsel),
		.cfg_wresp_req_in(state == ST_CFG_WR && fsel),
		.cfg_dw_in(h_reg),
		.cfg_wdata_in(h_data),
		.cfg_be_in(h_fbe),
		.cfg_rdata_valid_out(c_rdv[1]),
		.cfg_rdata_out(c_rdata1),
		.cfg_wresp_valid_out(c_wrv[1]),
		.mem_rd_in(state == ST_MEM && fsel && !has_data),
		.mem_wr_in(state == ST_MEM && fsel && has_data),
		.mem_sel_in(h_addr[2]),
		.mem_wdata_in(h_data),
		.mem_be_in(h_fbe),
		.mem_wait_out(m_wait[1]),
		.mem_rdata_out(m_rdata1),
		.bar_base_out(bar1)
	);

	// completion beat built from the values about to be loaded
	csb_cpl u_cpl (
		.status_in(next_status),
		.with_data_in(next_with_data),
		.data_in(next_cdata),
		.cpl_id_in(cpl_id),
		.req_id_in(h_req),
		.tag_in(h_tag),
		.lower_addr_in(cpl_lower),
		.payload_out(cpl_beat)
	);

	// request sequencing; one request is in flight at a time, which
	// costs throughput but keeps completions in request order
	always @* begin
		next_state = state;
		next_fsel = fsel;
		next_status = `CSB_ST_SC;
		next_with_data = 1'b0;
		next_cdata = 32'h00000000;
		case (state)
		ST_IDLE: begin
			if (take)
				next_state = rx_stream_packet_end_in ? ST_DEC : ST_DRAIN;
		end
		ST_DEC: begin
			if (is_cfg0 && h_func[2:1] == 2'b00) begin
				next_fsel = h_func[0];
				next_state = has_data ? ST_CFG_WR : ST_CFG_RD;
			end else if (is_cfg0 || is_cfg1) begin
				next_status = `CSB_ST_UR;
				next_state = ST_TX;
			end else if (is_mem && !has_data) begin
				if (!one_dw) begin
					next_status = `CSB_ST_CA;
					next_state = ST_TX;
				end else if (hit0 || hit1) begin
					next_fsel = hit1 && !hit0;
					next_state = ST_MEM;
				end else begin
					next_status = `CSB_ST_UR;
					next_state = ST_TX;
				end
			end else if (is_mem && one_dw && (hit0 || hit1)) begin
				next_fsel = hit1 && !hit0;
				next_state = ST_MEM;
			end else begin
				next_state = ST_IDLE;
			end
		end
		ST_CFG_RD: begin
			if (sel_rdv) begin
				next_with_data = 1'b1;
				next_cdata = sel_cfg_rdata;
				next_state = ST_TX;
			end
		end
		ST_CFG_WR: begin
			if (sel_wrv)
				next_state = ST_TX;
		end
		ST_MEM: begin
			if (!sel_wait) begin
				if (has_data) begin
					next_state = ST_IDLE;
				end else begin
					next_with_data = 1'b1;
					next_cdata = sel_mem_rdata;
					next_state = ST_TX;
				end
			end
		end
		ST_DRAIN: begin
			// the tail of an over-long packet is swallowed
			if (rx_stream_word_valid_in && rx_stream_packet_end_in)
				next_state = ST_IDLE;
		end
		ST_TX: begin
			if (tx_stream_accept_ready_in)
				next_state = ST_IDLE;
		end
		default: next_state = ST_IDLE;
		endcase
	end

	// header capture on the accepted start beat
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			h_fmt <= 3'h0;
			h_type <= 5'h00;
			h_len <= 10'h000;
			h_req <= 16'h0000;
			h_tag <= 8'h00;
			h_fbe <= 4'h0;
			h_func <= 3'h0;
			h_reg <= 10'h000;
			h_addr <= 64'h0;
			h_data <= 32'h00000000;
		end else if (take) begin
			h_fmt <= dw0[`CSB_FMT_MSB:`CSB_FMT_LSB];
			h_type <= dw0[`CSB_TYPE_MSB:`CSB_TYPE_LSB];
			h_len <= dw0[`CSB_LEN_MSB:0];
			h_req <= dw1[31:16];
			h_tag <= dw1[15:8];
			h_fbe <= dw1[3:0];
			h_func <= dw2[18:16];
			h_reg <= dw2[11:2];
			// short headers carry a 32-bit address and data in dword 3
			h_addr <= dw0[`CSB_FMT_4DW + `CSB_FMT_LSB] ?
				{dw2, dw3} : {32'h00000000, dw2};
			h_data <= dw0[`CSB_FMT_4DW + `CSB_FMT_LSB] ? dw4 : dw3;
		end
	end

	// state, ready and the transmit beat, all registered
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state <= ST_IDLE;
			fsel <= 1'b0;
			rx_stream_accept_ready_out <= 1'b0;
			tx_stream_payload_out <= 256'h0;
			tx_stream_packet_start_out <= 1'b0;
			tx_stream_packet_end_out <= 1'b0;
			tx_stream_word_valid_out <= 1'b0;
		end else begin
			state <= next_state;
			fsel <= next_fsel;
			// ready only while idle or draining a dropped tail
			rx_stream_accept_ready_out <= (next_state == ST_IDLE) ||
				(next_state == ST_DRAIN);
			if (next_state == ST_TX && state != ST_TX) begin
				tx_stream_payload_out <= cpl_beat;
				tx_stream_packet_start_out <= 1'b1;
				tx_stream_packet_end_out <= 1'b1;
				tx_stream_word_valid_out <= 1'b1;
			end else if (state == ST_TX && tx_stream_accept_ready_in) begin
				tx_stream_packet_start_out <= 1'b0;
				tx_stream_packet_end_out <= 1'b0;
				tx_stream_word_valid_out <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

//--- csb_core_model.sv
// model of the core's streaming side that faces the bypass bridge
`timescale 1ns/1ns
`default_nettype none
module csb_core_model (
	// clock and reset
	input wire logic clk_in,
	input wire logic reset_n_in,
	// request stream towards the bridge
	output logic [255:0] rx_payload_out,
	output logic rx_start_out,
	output logic rx_end_out,
	output logic rx_valid_out,
	input wire logic rx_ready_in,
	// completion stream from the bridge
	input wire logic tx_valid_in,
	input wire logic [1:0] stall_in,
	output logic tx_ready_out
);
	logic [1:0] wait_cnt;

	// idle stream at time zero
	initial begin
		rx_payload_out = 256'h0;
		rx_start_out = 1'b0;
		rx_end_out = 1'b0;
		rx_valid_out = 1'b0;
	end

	// completion accept, held off for a chosen number of cycles
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			tx_ready_out <= #1 1'b0;
			wait_cnt <= #1 2'h0;
		end else if (tx_valid_in && !tx_ready_out && wait_cnt != 2'h0) begin
			wait_cnt <= #1 wait_cnt - 2'h1;
		end else if (tx_valid_in && !tx_ready_out) begin
			tx_ready_out <= #1 1'b1;
		end else begin
			tx_ready_out <= #1 1'b0;
			wait_cnt <= #1 stall_in;
		end
	end

	// each beat is held until an edge sees ready; bounded wait
	task automatic send(input logic [159:0] h, input int nb, output bit ok);
		int n;
		ok = 1'b1;
		@(posedge clk_in);
		for (int b = 0; b < nb; b++) begin
			#1;
			rx_payload_out = {96'h0, h};
			rx_start_out = (b == 0);
			rx_end_out = (b == nb - 1);
			rx_valid_out = 1'b1;
			n = 0;
			do begin
				@(posedge clk_in);
				n++;
			end while (!rx_ready_in && n < 40);
			if (!rx_ready_in)
				ok = 1'b0;
		end
		// released lines show garbage, not the old request
		#1;
		rx_valid_out = 1'b0;
		rx_start_out = 1'b0;
		rx_end_out = 1'b0;
		rx_payload_out = ~rx_payload_out;
	endtask
endmodule
`default_nettype wire

//--- csb_bridge_assertions.sv
// timing and framing checks on the bridge's stream ports
`timescale 1ns/1ns
`default_nettype none
module csb_bridge_assertions (
	// clock and reset
	input wire clk_in,
	input wire reset_n_in,
	// receive stream
	input wire [255:0] rx_stream_payload_in,
	input wire rx_stream_packet_start_in,
	input wire rx_stream_packet_end_in,
	input wire rx_stream_word_valid_in,
	input wire rx_stream_accept_ready_out,
	// transmit stream
	input wire tx_stream_accept_ready_in,
	input wire [255:0] tx_stream_payload_out,
	input wire tx_stream_packet_start_out,
	input wire tx_stream_packet_end_out,
	input wire tx_stream_word_valid_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	// short views; take is a whole single-beat request accepted
	wire [255:0] rp = rx_stream_payload_in;
	wire [255:0] tp = tx_stream_payload_out;
	wire tv = tx_stream_word_valid_out;
	wire tr = tx_stream_accept_ready_in;
	wire rr = rx_stream_accept_ready_out;
	wire take = rr & rx_stream_word_valid_in & rx_stream_packet_start_in
		& rx_stream_packet_end_in;
	wire cfg_ok = rp[28:24] == 5'h04 && rp[82:81] == 2'h0;
	wire [2:0] st = tp[47:45];

	a_take_drops_ready: assert property (
		take |=> !rr) else $error("ready held after a take");
	a_busy_no_ready: assert property (
		tv |-> !rr) else $error("ready shown during a completion");
	a_ready_returns: assert property (
		tv && tr |=> !tv && rr) else $error("no clean hand-back");
	a_cpl_held: assert property (
		tv && !tr |=> tv && $stable(tp)) else $error("completion dropped");
	a_cpl_frame: assert property (
		tv |-> tx_stream_packet_start_out && tx_stream_packet_end_out
		&& tp[28:24] == 5'h0a && tp[255:128] == 128'h0)
		else $error("bad completion frame");
	a_cfg_rd_time: assert property (
		take && rp[31:29] == 3'h0 && cfg_ok |-> ##4 tv && tp[31:29] == 3'h2
		&& st == 3'h0) else $error("config read completion late");
	a_cfg_wr_time: assert property (
		take && rp[31:29] == 3'h2 && cfg_ok |-> ##4 tv && tp[31:29] == 3'h0
		&& st == 3'h0) else $error("config write completion late");
	a_cfg_bad_ur: assert property (
		take && (rp[28:24] == 5'h05 || (rp[28:24] == 5'h04 && !cfg_ok))
		|-> ##2 tv && st == 3'h1) else $error("no unsupported status");
	a_long_rd_ca: assert property (
		take && rp[31:30] == 2'h0 && rp[28:24] == 5'h00 && rp[9:0] != 10'h001
		|-> ##2 tv && st == 3'h4) else $error("no abort status");
	a_write_silent: assert property (
		take && rp[31:30] == 2'h1 && rp[28:24] == 5'h00 |=> !tv [*4])
		else $error("write was answered");
	a_msg_silent: assert property (
		take && rp[28:27] == 2'h2 |=> !tv [*4]) else $error("message answered");
endmodule

bind csb_bridge csb_bridge_assertions u_chk (
	.clk_in(clk_in),
	.reset_n_in(reset_n_in),
	.rx_stream_payload_in(rx_stream_payload_in),
	.rx_stream_packet_start_in(rx_stream_packet_start_in),
	.rx_stream_packet_end_in(rx_stream_packet_end_in),
	.rx_stream_word_valid_in(rx_stream_word_valid_in),
	.rx_stream_accept_ready_out(rx_stream_accept_ready_out),
	.tx_stream_accept_ready_in(tx_stream_accept_ready_in),
	.tx_stream_payload_out(tx_stream_payload_out),
	.tx_stream_packet_start_out(tx_stream_packet_start_out),
	.tx_stream_packet_end_out(tx_stream_packet_end_out),
	.tx_stream_word_valid_out(tx_stream_word_valid_out)
);
`default_nettype wire

//--- csb_bridge_tb.sv
// self-checking bench for the configuration bypass bridge
`timescale 1ns/1ns
`default_nettype none
module csb_bridge_tb;
	// identity codes for this run, values arbitrary
	localparam logic [15:0] VID = 16'h3c3c;
	localparam logic [15:0] DID = 16'hc3c3;
	logic clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic [255:0] rx_pl, tx_pl;
	logic rx_sop, rx_eop, rx_val, rx_rdy, tx_rdy, tx_sop, tx_eop, tx_val;
	logic [1:0] stall = 2'h0;
	logic [7:0] tg = 8'h00;
	logic [127:0] exp_q[$], msk_q[$];
	logic [31:0] rv[4];
	int n_mismatch = 0;
	int total_checks = 0;

	always #10 clk_in = ~clk_in;

	csb_bridge #(.VENDOR_ID(VID), .DEVICE_ID(DID)) DUT (
		.clk_in(clk_in), .reset_n_in(reset_n_in),
		.rx_stream_payload_in(rx_pl), .rx_stream_packet_start_in(rx_sop),
		.rx_stream_packet_end_in(rx_eop), .rx_stream_word_valid_in(rx_val),
		.rx_stream_accept_ready_out(rx_rdy),
		.tx_stream_accept_ready_in(tx_rdy), .tx_stream_payload_out(tx_pl),
		.tx_stream_packet_start_out(tx_sop), .tx_stream_packet_end_out(tx_eop),
		.tx_stream_word_valid_out(tx_val));

	csb_core_model u_core (
		.clk_in(clk_in), .reset_n_in(reset_n_in), .rx_payload_out(rx_pl),
		.rx_start_out(rx_sop), .rx_end_out(rx_eop), .rx_valid_out(rx_val),
		.rx_ready_in(rx_rdy), .tx_valid_in(tx_val), .stall_in(stall),
		.tx_ready_out(tx_rdy));

	task automatic check(input logic [255:0] seen, input logic [255:0] want);
		total_checks++;
		if (seen !== want) begin
			n_mismatch++;
			$display("[ERR] %0t seen %h want %h", $time, seen, want);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// headers; dword 0 in the low bits, requester id fixed
	function automatic logic [159:0] cfg(input logic [2:0] fm,
			input logic [4:0] ty, input logic [2:0] fn, input logic [9:0] rg,
			input logic [31:0] d);
		tg = tg + 8'h01;
		return {32'h0, d, 13'h0, fn, 4'h0, rg, 2'b00, 16'h0100, tg, 8'h0f,
			fm, ty, 14'h0, 10'h001};
	endfunction
	function automatic logic [159:0] mem(input logic [2:0] fm,
			input logic [4:0] ty, input logic [9:0] ln, input logic [63:0] a,
			input logic [31:0] d);
		tg = tg + 8'h01;
		return {d, a[31:0], a[63:32], 16'h0100, tg,
			ln == 10'h001 ? 8'h0f : 8'hff, fm, ty, 14'h0, ln};
	endfunction
	// windows as software programs them: function 1 right above function 0
	function automatic logic [63:0] adr(input int f, input int r);
		return 64'h100000000 + (64'(f) << 20) + 64'(r * 4);
	endfunction

	// note the completion, send, then wait a bounded time for it
	task automatic req(input logic [159:0] h, input int nb, input bit cp,
			input logic [2:0] st, input bit wd, input logic [2:0] fn,
			input logic [31:0] d);
		bit ok;
		int n;
		logic [127:0] e, m;
		e = {d, 16'h0100, h[47:40], 8'h00, 13'h0, fn, st, 13'h004,
			wd ? 32'h4a000001 : 32'h0a000000};
		// lower address, absent data and unknown completer are not compared
		m = {wd ? 32'hffffffff : 32'h0, 32'hffffff80,
			fn == 3'h7 ? 32'h0000ffff : 32'hffffffff, 32'hffffffff};
		if (cp) begin
			exp_q.push_back(e & m);
			msk_q.push_back(m);
		end
		@(posedge clk_in);
		#1;
		stall = 2'($urandom_range(3));
		u_core.send(h, nb, ok);
		n = 0;
		while (exp_q.size() != 0 && n < 40) begin
			@(posedge clk_in);
			n++;
		end
		if (!ok || exp_q.size() != 0) begin
			n_mismatch++;
			finish_test();
		end
	endtask
	task automatic crd(input int f, input logic [9:0] rg, input logic [31:0] x);
		req(cfg(3'h0, 5'h04, 3'(f), rg, 32'h0), 1, 1, 3'h0, 1, 3'(f), x);
	endtask
	task automatic cwr(input int f, input logic [9:0] rg, input logic [31:0] d);
		req(cfg(3'h2, 5'h04, 3'(f), rg, d), 1, 1, 3'h0, 0, 3'(f), 32'h0);
	endtask
	task automatic mwr(input int f, input int r, input logic [9:0] ln,
			input logic [31:0] d);
		req(mem(3'h3, 5'h00, ln, adr(f, r), d), 1, 0, 3'h0, 0, 3'h0, 32'h0);
	endtask
	task automatic mrd(input int f, input int r, input logic [31:0] x);
		req(mem(3'h1, 5'h00, 10'h001, adr(f, r), 32'h0), 1, 1, 3'h0, 1,
			3'(f), x);
	endtask

	// compare each accepted completion with the oldest note
	always @(posedge clk_in) begin
		if (tx_val === 1'b1 && tx_rdy === 1'b1) begin
			if (exp_q.size() == 0)
				check(tx_pl, 256'h0);
			else
				check(tx_pl & {{128{1'b1}}, msk_q.pop_front()},
					{128'h0, exp_q.pop_front()});
		end
	end

	initial begin
		void'($urandom(81));
		repeat (2) @(posedge clk_in);
		#1;
		reset_n_in = 1'b1;
		repeat (2) @(posedge clk_in);
		// fixed space, command bits and region zero of each function
		for (int f = 0; f < 2; f++) begin
			crd(f, 10'h000, {DID, VID});
			crd(f, 10'h002, 32'h00000001);
			crd(f, 10'h003, 32'h00000000);
			cwr(f, 10'h001, 32'hffffffff);
			crd(f, 10'h001, 32'h00000007);
			cwr(f, 10'h004, 32'hffffffff);
			crd(f, 10'h004, 32'hfff0000c);
			cwr(f, 10'h004, f ? 32'h00100000 : 32'h00000000);
			cwr(f, 10'h005, 32'h00000001);
		end
		// random contents in all four registers, then read all back
		for (int k = 0; k < 4; k++) begin
			rv[k] = $urandom;
			mwr(k / 2, k % 2, 10'h001, rv[k]);
		end
		for (int k = 0; k < 4; k++)
			mrd(k / 2, k % 2, rv[k]);
		// refused and dropped requests
		req(cfg(3'h0, 5'h04, 3'h2, 10'h000, 0), 1, 1, 3'h1, 0, 7, 0);
		req(cfg(3'h2, 5'h05, 3'h0, 10'h000, 0), 1, 1, 3'h1, 0, 7, 0);
		mwr(0, 0, 10'h002, ~rv[0]);
		req(mem(3'h3, 5'h10, 10'h001, 64'h0, 0), 1, 0, 3'h0, 0, 0, 0);
		req(mem(3'h1, 5'h00, 10'h001, adr(0, 0), 0), 2, 0, 3'h0, 0, 0, 0);
		mrd(0, 0, rv[0]);
		req(mem(3'h1, 5'h00, 10'h002, adr(0, 1), 0), 1, 1, 3'h4, 0, 7, 0);
		req(mem(3'h1, 5'h00, 10'h001, 64'h2 << 32, 0), 1, 1, 3'h1, 0, 7, 0);
		finish_test();
	end
endmodule
`default_nettype wire
